// file: core/cascade_timer.sv
// Cascaded 32-bit periodic timer stepped by a tick of about 4.17 MHz (25 MHz / 6).
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
`include "irq_combiner_defs.svh"

module cascade_timer #(
   parameter int WIDTH = 32
) (
   input wire logic clk_in, // System clock.
   input wire logic srst_in, // Synchronous reset.
   input wire logic tick_in, // One-cycle base tick.
   input wire logic load_in, // Reload pulse.
   input wire logic [WIDTH-1:0] period_in, // Period in ticks.
   output logic cascade_timer_out // High for one tick at terminal count.
);
   import irq_combiner_pkg::*;

   logic [WIDTH-1:0] count_q;

   // ===========================================================================
   // Down counter; the output pulses high as it reloads from period_in.
   always_ff @(posedge clk_in) begin
      if (srst_in || load_in) begin
         count_q <= period_in;
         cascade_timer_out <= 1'b0;
      end else if (tick_in) begin
         if (count_q <= WIDTH'(1) && period_in != '0) begin
            count_q <= period_in;
            cascade_timer_out <= 1'b1;
         end else begin
            count_q <= count_q - WIDTH'(1);
            cascade_timer_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: core/irq_combiner.sv
// Three-channel interrupt combiner with event counter and cascaded timer.
// Assumes a synchronous register port and asynchronous pins for the trigger inputs.
//
// Contract
// - Three channels: external, event, periodic timer.
// - Host interrupt output active low, level.
// - Equal priority, one combined assertion.
// - Channel 0 from fourth counter gate pin.
// - Channel 0 enable gates channel 0.
// - Channel 0 polarity 0 inverts source.
// - Channel 1 from event counter output.
// - Channel 1 enable gates channel 1.
// - Channel 1 polarity 0 inverts source.
// - Channel 2 from 32-bit cascaded timer.
// - Channel 2 enable gates channel 2.
// - Channel 2 polarity 0 inverts source.
// - All enables reset to zero.
// - Polarity register at offset 0x2A.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "irq_combiner_defs.svh"

module irq_combiner #(
   parameter int EVENT_WIDTH = 16,
   parameter int TIMER_WIDTH = 32
) (
   input wire logic clk_in, // 25 MHz system clock.
   input wire logic srst_in, // Synchronous reset, active high.
   input wire logic [7:0] addr_in, // Register byte address.
   input wire logic [7:0] wdata_in, // Write data.
   input wire logic wr_in, // Write strobe.
   input wire logic rd_in, // Read strobe.
   input wire logic [EVENT_WIDTH-1:0] event_preset_in, // Event counter setting.
   input wire logic event_load_in, // Load pulse for the event counter.
   input wire logic [TIMER_WIDTH-1:0] timer_period_in, // Timer period in ticks.
   input wire logic timer_load_in, // Load pulse for the timer.
   input wire logic fourth_counter_gate_in, // External trigger pin.
   input wire logic event_pin_in, // Event pulse pin.
   output logic [7:0] rdata_out, // Read data, one cycle after the strobe.
   output logic irq_n_out, // Combined host interrupt, active low.
   output logic pend_irq_out // Sticky pending interrupt, active high.
);
   import irq_combiner_pkg::*;

   localparam int TICK_DIV = `IRQC_CLK_HZ / `IRQC_TIMER_HZ;

   chan_vec_t enable_q, polarity_q, pending_q, pend_en_q, chan_q;
   chan_vec_t src;
   logic [1:0] gate_sync_q, event_sync_q;
   logic event_prev_q;
   logic [EVENT_WIDTH-1:0] event_count_q;
   logic event_counter_out;
   logic cascade_timer_out;
   logic [3:0] tick_cnt_q;
   logic tick_q;
   logic [7:0] rdata_q;
   logic irq_n_q;
   logic pend_irq_q;
   logic wr_enable, wr_polarity, wr_clear, wr_pend_en;

   assign wr_enable = wr_in && addr_in == `IRQC_ENABLE_OFS;
   assign wr_polarity = wr_in && addr_in == `IRQC_POLARITY_OFS;
   assign wr_clear = wr_in && addr_in == `IRQC_CLEAR_OFS;
   assign wr_pend_en = wr_in && addr_in == `IRQC_PEND_EN_OFS;

   // ===========================================================================
   // Pin synchronisers.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         gate_sync_q <= 2'h0;
         event_sync_q <= 2'h0;
      end else begin
         gate_sync_q <= {gate_sync_q[0], fourth_counter_gate_in};
         event_sync_q <= {event_sync_q[0], event_pin_in};
      end
   end

   // ===========================================================================
   // Event counter: counts rising pin edges and holds high at the setting.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         event_prev_q <= 1'b0;
         event_count_q <= '0;
         event_counter_out <= 1'b0;
      end else begin
         event_prev_q <= event_sync_q[1];
         if (event_load_in) begin
            event_count_q <= '0;
            event_counter_out <= 1'b0;
         end else if (event_sync_q[1] && !event_prev_q && !event_counter_out) begin
            event_count_q <= event_count_q + EVENT_WIDTH'(1);
            if (event_count_q + EVENT_WIDTH'(1) == event_preset_in) begin
               event_counter_out <= 1'b1;
            end
         end
      end
   end

   // ===========================================================================
   // Base tick every 6 clocks (25 MHz / 6, about 4.17 MHz) for the cascaded timer.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         tick_cnt_q <= 4'h0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == 4'(TICK_DIV - 1)) begin
         tick_cnt_q <= 4'h0;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 4'h1;
         tick_q <= 1'b0;
      end
   end

   cascade_timer #(
      .WIDTH(TIMER_WIDTH)
   ) u_timer (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .tick_in(tick_q),
      .load_in(timer_load_in),
      .period_in(timer_period_in),
      .cascade_timer_out(cascade_timer_out)
   );

   assign src = {cascade_timer_out, event_counter_out, gate_sync_q[1]};

   // ===========================================================================
   // Control registers.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         enable_q <= `IRQC_ENABLE_RST;
      end else if (wr_enable) begin
         enable_q <= wdata_in[2:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         polarity_q <= `IRQC_POLARITY_RST;
      end else if (wr_polarity) begin
         polarity_q <= wdata_in[2:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pend_en_q <= `IRQC_PEND_EN_RST;
      end else if (wr_pend_en) begin
         pend_en_q <= wdata_in[2:0];
      end
   end

   // ===========================================================================
   // Per-channel polarity select; polarity 0 inverts the source.
   generate
      for (genvar i = 0; i < 3; i++) begin : g_chan
         always_ff @(posedge clk_in) begin
            if (srst_in) begin
               chan_q[i] <= 1'b0;
            end else begin
               chan_q[i] <= polarity_q[i] ? src[i] : !src[i];
            end
         end
         always_ff @(posedge clk_in) begin
            if (srst_in) begin
               pending_q[i] <= 1'b0;
            end else if (chan_q[i]) begin
               pending_q[i] <= 1'b1;
            end else if (wr_clear && wdata_in[i]) begin
               pending_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // ===========================================================================
   // Combined output: every channel weighs the same, one wire for all.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= !(|(chan_q & enable_q));
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pend_irq_q <= 1'b0;
      end else begin
         pend_irq_q <= |(pending_q & pend_en_q);
      end
   end

   // ===========================================================================
   // Read port.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rdata_q <= 8'h00;
      end else if (rd_in) begin
         case (addr_in)
            `IRQC_ENABLE_OFS: rdata_q <= {5'h00, enable_q};
            `IRQC_POLARITY_OFS: rdata_q <= {5'h00, polarity_q};
            `IRQC_STATUS_OFS: rdata_q <= {5'h00, chan_q};
            `IRQC_PENDING_OFS: rdata_q <= {5'h00, pending_q};
            `IRQC_PEND_EN_OFS: rdata_q <= {5'h00, pend_en_q};
            `IRQC_SOURCE_OFS: rdata_q <= {5'h00, src};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata_out = rdata_q;
   assign irq_n_out = irq_n_q;
   assign pend_irq_out = pend_irq_q;

   // ===========================================================================
   // Checks.
   property p_enable_reset;
      @(posedge clk_in) srst_in |=> enable_q == `IRQC_ENABLE_RST;
   endproperty
   a_enable_reset: assert property (p_enable_reset) else $error("enable not cleared");

   property p_output_low;
      @(posedge clk_in) disable iff (srst_in) |(chan_q & enable_q) |=> !irq_n_out;
   endproperty
   a_output_low: assert property (p_output_low) else $error("irq not low");

   property p_output_high;
      @(posedge clk_in) disable iff (srst_in) !(|(chan_q & enable_q)) |=> irq_n_out;
   endproperty
   a_output_high: assert property (p_output_high) else $error("irq not high");

   property p_ch0_gate;
      @(posedge clk_in) disable iff (srst_in)
         (enable_q == 3'h0) [*2] |-> irq_n_out;
   endproperty
   a_ch0_gate: assert property (p_ch0_gate) else $error("disabled channel fired");

   property p_polarity;
      @(posedge clk_in) disable iff (srst_in)
         $stable(polarity_q) |=> chan_q[0] == ($past(polarity_q[0]) ~^ $past(src[0]));
   endproperty
   a_polarity: assert property (p_polarity) else $error("ch0 polarity wrong");

   property p_polarity1;
      @(posedge clk_in) disable iff (srst_in)
         $stable(polarity_q) |=> chan_q[1] == ($past(polarity_q[1]) ~^ $past(src[1]));
   endproperty
   a_polarity1: assert property (p_polarity1) else $error("ch1 polarity wrong");

   property p_polarity2;
      @(posedge clk_in) disable iff (srst_in)
         $stable(polarity_q) |=> chan_q[2] == ($past(polarity_q[2]) ~^ $past(src[2]));
   endproperty
   a_polarity2: assert property (p_polarity2) else $error("ch2 polarity wrong");

   property p_pol_write;
      @(posedge clk_in) disable iff (srst_in)
         wr_in && addr_in == 8'h2A |=> polarity_q == $past(wdata_in[2:0]);
   endproperty
   a_pol_write: assert property (p_pol_write) else $error("polarity write lost");

   property p_status_read;
      @(posedge clk_in) disable iff (srst_in)
         rd_in && addr_in == `IRQC_STATUS_OFS |=> rdata_out == {5'h00, $past(chan_q)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_ch1_pass;
      @(posedge clk_in) disable iff (srst_in) enable_q[1] && chan_q[1] |=> !irq_n_out;
   endproperty
   a_ch1_pass: assert property (p_ch1_pass) else $error("ch1 not passed");

   property p_ch0_pass;
      @(posedge clk_in) disable iff (srst_in) enable_q[0] && chan_q[0] |=> !irq_n_out;
   endproperty
   a_ch0_pass: assert property (p_ch0_pass) else $error("ch0 not passed");

   property p_ch2_pass;
      @(posedge clk_in) disable iff (srst_in) enable_q[2] && chan_q[2] |=> !irq_n_out;
   endproperty
   a_ch2_pass: assert property (p_ch2_pass) else $error("ch2 not passed");

   property p_ch0_block;
      @(posedge clk_in) disable iff (srst_in)
         chan_q[0] && !enable_q[0] && (chan_q[2:1] & enable_q[2:1]) == 2'h0 |=> irq_n_out;
   endproperty
   a_ch0_block: assert property (p_ch0_block) else $error("ch0 not blocked");

   property p_ch1_block;
      @(posedge clk_in) disable iff (srst_in)
         chan_q[1] && !enable_q[1] && (chan_q & enable_q & 3'h5) == 3'h0 |=> irq_n_out;
   endproperty
   a_ch1_block: assert property (p_ch1_block) else $error("ch1 not blocked");

   property p_ch2_block;
      @(posedge clk_in) disable iff (srst_in)
         chan_q[2] && !enable_q[2] && (chan_q[1:0] & enable_q[1:0]) == 2'h0 |=> irq_n_out;
   endproperty
   a_ch2_block: assert property (p_ch2_block) else $error("ch2 not blocked");

   property p_single_assert;
      @(posedge clk_in) disable iff (srst_in)
         !irq_n_out && (|(chan_q & enable_q)) |=> !irq_n_out;
   endproperty
   a_single_assert: assert property (p_single_assert) else $error("irq toggled");

   property p_gate_source;
      @(posedge clk_in) disable iff (srst_in)
         !$past(srst_in) && !$past(srst_in, 2) |-> src[0] == $past(fourth_counter_gate_in, 2);
   endproperty
   a_gate_source: assert property (p_gate_source) else $error("ch0 source wrong");

   property p_event_hold;
      @(posedge clk_in) disable iff (srst_in)
         event_counter_out && !event_load_in |=> event_counter_out;
   endproperty
   a_event_hold: assert property (p_event_hold) else $error("event output dropped");

   property p_event_at_setting;
      @(posedge clk_in) disable iff (srst_in)
         $rose(event_counter_out) |-> event_count_q == event_preset_in;
   endproperty
   a_event_at_setting: assert property (p_event_at_setting) else $error("event early");

   property p_timer_on_tick;
      @(posedge clk_in) disable iff (srst_in)
         $rose(cascade_timer_out) |-> $past(tick_q);
   endproperty
   a_timer_on_tick: assert property (p_timer_on_tick) else $error("timer off tick");

   property p_pol_read;
      @(posedge clk_in) disable iff (srst_in)
         rd_in && addr_in == `IRQC_POLARITY_OFS |=> rdata_out == {5'h00, $past(polarity_q)};
   endproperty
   a_pol_read: assert property (p_pol_read) else $error("polarity read wrong");
endmodule
`default_nettype wire

// file: core/irq_combiner_defs.svh
// Offsets, field positions, reset values and timing counts of the interrupt combiner.
// Assumes a byte-addressed 8-bit register port at 25 MHz.
`ifndef IRQ_COMBINER_DEFS_SVH
`define IRQ_COMBINER_DEFS_SVH

// ===========================================================================
// Register offsets
`define IRQC_ENABLE_OFS 8'h05
`define IRQC_POLARITY_OFS 8'h2A
`define IRQC_STATUS_OFS 8'h07
`define IRQC_PENDING_OFS 8'h08
`define IRQC_CLEAR_OFS 8'h09
`define IRQC_PEND_EN_OFS 8'h0A
`define IRQC_SOURCE_OFS 8'h0B

// ===========================================================================
// Field positions and reset values
`define IRQC_CH_EXTERNAL 0
`define IRQC_CH_EVENT 1
`define IRQC_CH_TIMER 2
`define IRQC_ENABLE_RST 3'h0
`define IRQC_POLARITY_RST 3'h7
`define IRQC_PEND_EN_RST 3'h0

// ===========================================================================
// Timing
`define IRQC_CLK_HZ 25000000
`define IRQC_TIMER_HZ 4000000
`define IRQC_HOLD_MS 20

`endif

// file: core/irq_combiner_pkg.sv
// Types shared by the interrupt combiner files.
// Assumes nothing beyond the defs header.
package irq_combiner_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] chan_vec_t;
   typedef enum logic [1:0] {
      TICK_IDLE,
      TICK_HIGH
   } tick_state_t;
endpackage

// file: tb/irq_host.sv
// Host side of the combined interrupt line: counts interrupt entries.
// Assumes the line is sampled on the system clock.
`timescale 1ns/100ps
`default_nettype none
module irq_host (
   input wire logic clk_in, // System clock.
   input wire logic irq_n_in // Combined interrupt, active low.
);
   int irq_cnt = 0;
   logic last_q = 1'b1;
   // A fall of the line is one entry; a line held low is not counted again.
   always @(posedge clk_in) begin
      if (last_q && !irq_n_in) irq_cnt <= irq_cnt + 1;
      last_q <= irq_n_in;
   end
endmodule
`default_nettype wire

// file: tb/test_three_channel_irq_combiner.sv
// Self-checking bench of the interrupt combiner against a small integer model.
// Assumes the defs header and package of the core are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "irq_combiner_defs.svh"
module test_three_channel_irq_combiner;
   import irq_combiner_pkg::*;
   // ======================================================================
   // Stimulus and model state
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   byte_t addr = 8'h00;
   byte_t wdata = 8'h00;
   byte_t rdata;
   logic wr = 1'b0, rd = 1'b0, ev_load = 1'b0, tm_load = 1'b0, gate = 1'b0, ev_pin = 1'b0;
   logic [15:0] preset = 16'h0000;
   logic [31:0] period = 32'h0000_0000;
   logic irq_n, pend_irq;
   int error_cnt = 0, checked = 0, seed = 33, en_m = 0, pol_m = 7, src_m = 0, n, base;
   always #20 clk_in = ~clk_in;
   irq_combiner DUT (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .event_preset_in(preset), .event_load_in(ev_load),
      .timer_period_in(period), .timer_load_in(tm_load), .fourth_counter_gate_in(gate),
      .event_pin_in(ev_pin), .rdata_out(rdata), .irq_n_out(irq_n), .pend_irq_out(pend_irq));
   irq_host host_model (.clk_in(clk_in), .irq_n_in(irq_n));
   // ======================================================================
   // Compare, bus and source tasks
   task automatic chk_val(input string what, input byte_t exp, input byte_t got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic chk_line(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask
   function automatic byte_t stat_m();
      return 8'((pol_m & src_m | ~pol_m & ~src_m) & 7);
   endfunction
   task automatic chk_irq();
      chk_line("irq_n_out", (stat_m() & en_m) == 0, irq_n);
   endtask
   task automatic settle();
      repeat (5) @(posedge clk_in);
      #1;
   endtask
   task automatic wr_reg(input byte_t a, input byte_t d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
      if (a == `IRQC_ENABLE_OFS) en_m = d & 7;
      if (a == `IRQC_POLARITY_OFS) pol_m = d & 7;
   endtask
   task automatic rd_reg(input byte_t a, input byte_t exp, input string what);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
      chk_val(what, exp, rdata);
   endtask
   // Sources rest low and pulse high, as the far side must keep them.
   task automatic ev_pulse();
      @(posedge clk_in);
      ev_pin <= 1'b1;
      repeat (3) @(posedge clk_in);
      ev_pin <= 1'b0;
      repeat (3 + ($random(seed) & 3)) @(posedge clk_in);
   endtask
   task automatic results();
      $display("checks %0d, errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ======================================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_in);
      srst_in <= 1'b0;
      ev_load <= 1'b1;
      @(posedge clk_in);
      ev_load <= 1'b0;
      #1;
      chk_line("irq_n_out", 1'b1, irq_n);
      rd_reg(`IRQC_ENABLE_OFS, 8'h00, "enable");
      rd_reg(`IRQC_POLARITY_OFS, 8'h07, "polarity");
      wr_reg(8'h33, 8'hFF);
      rd_reg(8'h33, 8'h00, "unmapped");
      rd_reg(`IRQC_STATUS_OFS, stat_m(), "status");
      // Every polarity setting against idle sources, with random enables.
      for (int p = 0; p < 8; p++) begin
         wr_reg(`IRQC_POLARITY_OFS, p[7:0]);
         wr_reg(`IRQC_ENABLE_OFS, 8'($random(seed) & 7));
         settle();
         chk_irq();
         rd_reg(`IRQC_STATUS_OFS, stat_m(), "status");
      end
      wr_reg(`IRQC_POLARITY_OFS, 8'h07);
      wr_reg(`IRQC_ENABLE_OFS, 8'h03);
      wr_reg(`IRQC_CLEAR_OFS, 8'h07);
      n = 2 + ($random(seed) & 3);
      preset <= n[15:0];
      ev_load <= 1'b1;
      @(posedge clk_in);
      ev_load <= 1'b0;
      repeat (n - 1) ev_pulse();
      settle();
      rd_reg(`IRQC_STATUS_OFS, 8'h00, "status");
      chk_irq();
      base = host_model.irq_cnt;
      @(posedge clk_in);
      gate <= 1'b1;
      ev_pin <= 1'b1;
      src_m = 3;
      settle();
      chk_irq();
      rd_reg(`IRQC_STATUS_OFS, 8'h03, "status");
      rd_reg(`IRQC_SOURCE_OFS, 8'h03, "source");
      repeat (20) @(posedge clk_in);
      chk_val("host entries", 8'(base + 1), 8'(host_model.irq_cnt));
      wr_reg(`IRQC_POLARITY_OFS, 8'h06);
      settle();
      rd_reg(`IRQC_STATUS_OFS, stat_m(), "status");
      wr_reg(`IRQC_POLARITY_OFS, 8'h07);
      ev_pin <= 1'b0;
      wr_reg(`IRQC_ENABLE_OFS, 8'h00);
      settle();
      chk_irq();
      wr_reg(`IRQC_PEND_EN_OFS, 8'h02);
      settle();
      chk_line("pend_irq_out", 1'b1, pend_irq);
      rd_reg(`IRQC_PENDING_OFS, 8'h03, "pending");
      wr_reg(`IRQC_CLEAR_OFS, 8'h03);
      rd_reg(`IRQC_PENDING_OFS, 8'h03, "pending");
      gate <= 1'b0;
      ev_load <= 1'b1;
      @(posedge clk_in);
      ev_load <= 1'b0;
      src_m = 0;
      settle();
      wr_reg(`IRQC_CLEAR_OFS, 8'h03);
      rd_reg(`IRQC_PENDING_OFS, 8'h00, "pending");
      chk_line("pend_irq_out", 1'b0, pend_irq);
      // Periodic timer: one tick high each period, seen as a short low on the line.
      period <= 32'(2 + ($random(seed) & 3));
      tm_load <= 1'b1;
      @(posedge clk_in);
      tm_load <= 1'b0;
      wr_reg(`IRQC_ENABLE_OFS, 8'h04);
      n = 0;
      while (irq_n !== 1'b0 && n < 200) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      chk_line("timer irq_n_out", 1'b0, irq_n);
      repeat (8) @(posedge clk_in);
      #1;
      chk_line("timer irq_n_out", 1'b1, irq_n);
      results();
   end
endmodule
`default_nettype wire
